// >>> psrp_map.svh
`ifndef PSRP_MAP_SVH
`define PSRP_MAP_SVH

// register addresses
`define PSRP_ADDR_SETUP 8'hd0
`define PSRP_ADDR_VIEW1 8'hd1
`define PSRP_ADDR_CTRL 8'hd2
`define PSRP_ADDR_VIEW2 8'hd3

// frame shape
`define PSRP_ADDR_BITS 6'h07
`define PSRP_LOAD_EDGE 6'h09
`define PSRP_FRAME_BITS 6'h20
`define PSRP_COUNT_MAX 6'h3f
`define PSRP_COUNT_ZERO 6'h00
`define PSRP_COUNT_STEP 6'h01

// power-on values of both input registers, the shifters, the address and the synchronisers
`define PSRP_REG_RESET 24'h00_0000
`define PSRP_RX_RESET 32'h0000_0000
`define PSRP_SYNC_RESET 8'h00
`define PSRP_ADDR_RESET 8'h00

// setup register fields
`define PSRP_DIV_MSB 23
`define PSRP_DIV_LSB 8
`define PSRP_REF_MSB 7
`define PSRP_REF_LSB 4
`define PSRP_MODE_MSB 3
`define PSRP_MODE_LSB 2
`define PSRP_XTAL_BIT 1
`define PSRP_VIEW_BIT 0

// control register fields
`define PSRP_CNT_MSB 23
`define PSRP_CNT_LSB 15
`define PSRP_TEST_BIT 14
`define PSRP_DIR_MSB 13
`define PSRP_DIR_LSB 9
`define PSRP_OUT_MSB 8
`define PSRP_OUT_LSB 0
`define PSRP_GPO_SEL_BIT 8
`define PSRP_GPO_VAL_BIT 3

// synchroniser lanes
`define PSRP_LANE_SCLK 0
`define PSRP_LANE_STROBE 1
`define PSRP_LANE_DATA 2
`define PSRP_LANE_IO_LSB 3
`define PSRP_LANE_IO_MSB 7

`define PSRP_UNUSED4 4'h0

`endif

// >>> psrp_pkg.sv
package psrp_pkg;

   typedef struct packed {
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      logic [7:0] q;
   } psrp_sync_t;

   typedef struct packed {
      logic pin_out;
      logic pin_oe;
   } psrp_drv_t;

   typedef struct packed {
      logic strobe_d;
      logic sclk_d;
      logic [5:0] count;
      logic [31:0] rx;
      logic [7:0] addr;
      logic [23:0] tx;
      logic oe;
      logic [23:0] reg1;
      logic [23:0] reg2;
   } psrp_state_t;

endpackage : psrp_pkg

// >>> psrp_sync.sv
`include "psrp_map.svh"

module psrp_sync
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] raw,
   output logic [7:0] q
);
   psrp_pkg::psrp_sync_t st;
   psrp_pkg::psrp_sync_t next_st;

   // a lane changes only when the second and third stage agree
   always_comb
   begin
      next_st = st;
      next_st.s1 = raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < 8; i++)
      begin
         if (st.s2[i] == st.s3[i])
         begin
            next_st.q[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         st <= {4{`PSRP_SYNC_RESET}};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign q = st.q;
endmodule : psrp_sync

// >>> psrp_phase_drv.sv
module psrp_phase_drv
(
   input wire logic clk,
   input wire logic reset,
   input wire logic pump_up,
   input wire logic pump_down,
   input wire logic as_gpo,
   input wire logic gpo_value,
   output logic pin_out,
   output logic pin_oe
);
   psrp_pkg::psrp_drv_t st;
   psrp_pkg::psrp_drv_t next_st;

   // gpo_value when as_gpo, else high on up, low on down, released otherwise
   always_comb
   begin
      next_st = st;
      if (as_gpo)
      begin
         next_st.pin_out = gpo_value;
         next_st.pin_oe = 1'b1;
      end
      else if (pump_up)
      begin
         next_st.pin_out = 1'b1;
         next_st.pin_oe = 1'b1;
      end
      else if (pump_down)
      begin
         next_st.pin_out = 1'b0;
         next_st.pin_oe = 1'b1;
      end
      else
      begin
         next_st.pin_out = 1'b0;
         next_st.pin_oe = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign pin_out = st.pin_out;
   assign pin_oe = st.pin_oe;
endmodule : psrp_phase_drv

// >>> psrp_top.sv
// Behaviour
// (R1) two 24-bit writable registers hold all settings
// (R2) frame is 8 address then 24 data bits
// (R3) only addresses d0 through d3 decoded
// (R4) setup register: divider, reference, mode, crystal, view
// (R5) control register: counter, test, direction, output data
// (R6) d1 gives counter result or setup echo
// (R7) counter view adds two lock bits, four zero
// (R8) registers load only at strobe falling edge
// (R9) read data captured at ninth clock fall
// (R10) serial lines sampled through crystal-clock synchronisers
// (R11) no serial input while oscillator stopped
// (R12) controller sends one dummy frame after power-up
// (R13) two phase outputs carry same comparator result
// (R14) second phase output switchable to general output
// (R15) crystal select bit reads zero after power-on
// (R16) msb first, device drives data after ninth clock
`include "psrp_map.svh"

module psrp_top
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic XTAL_RUNNING,
   input wire logic SCLK_IN,
   input wire logic STROBE_IN,
   input wire logic DATA_IN,
   output logic DATA_OUT,
   output logic DATA_OE,
   input wire logic [17:0] COUNTER_RESULT,
   input wire logic [1:0] LOCK_STATUS,
   input wire logic [4:0] IO_PIN_IN,
   input wire logic PUMP_UP,
   input wire logic PUMP_DOWN,
   output logic PHASE_ERROR_OUT_A,
   output logic PHASE_ERROR_OE_A,
   output logic PHASE_ERROR_OUT_B,
   output logic PHASE_ERROR_OE_B,
   output logic [15:0] LOOP_DIVIDER,
   output logic [3:0] REFERENCE_SELECT,
   output logic [1:0] OPERATION_MODE,
   output logic CRYSTAL_FREQ_SELECT,
   output logic READBACK_VIEW_SELECT,
   output logic [8:0] COUNTER_CONTROL,
   output logic TEST_MODE,
   output logic [4:0] IO_DIRECTION,
   output logic [8:0] OUTPUT_DATA
);
   psrp_pkg::psrp_state_t st;
   psrp_pkg::psrp_state_t next_st;
   logic [7:0] sync_raw;
   logic [7:0] sync_q;
   logic sclk_s;
   logic strobe_s;
   logic data_s;
   logic [4:0] io_s;
   logic sclk_rise;
   logic sclk_fall;
   logic strobe_fall;
   logic strobe_rise;
   logic in_frame;
   logic is_read;
   logic load_read;
   logic write_setup;
   logic write_ctrl;
   logic [23:0] view1;
   logic [23:0] view2;
   logic [23:0] read_view;
   logic gpo_select;

   // all three lines and the input pins share one synchroniser
   assign sync_raw = {IO_PIN_IN, DATA_IN, STROBE_IN, SCLK_IN};

   psrp_sync u_sync // [R10]
   (
      .clk(CLK),
      .reset(RESET),
      .raw(sync_raw),
      .q(sync_q)
   );

   assign sclk_s = sync_q[`PSRP_LANE_SCLK];
   assign strobe_s = sync_q[`PSRP_LANE_STROBE];
   assign data_s = sync_q[`PSRP_LANE_DATA];
   assign io_s = sync_q[`PSRP_LANE_IO_MSB:`PSRP_LANE_IO_LSB];

   // a stopped oscillator freezes the port entirely
   assign sclk_rise = XTAL_RUNNING && sclk_s && !st.sclk_d; // [R11]
   assign sclk_fall = XTAL_RUNNING && !sclk_s && st.sclk_d; // [R11]
   assign strobe_rise = XTAL_RUNNING && strobe_s && !st.strobe_d;
   assign strobe_fall = XTAL_RUNNING && !strobe_s && st.strobe_d; // [R11]
   assign in_frame = strobe_s;

   // d1 and d3 are the read views
   assign is_read = (st.addr == `PSRP_ADDR_VIEW1) || (st.addr == `PSRP_ADDR_VIEW2); // [R3]

   assign load_read = in_frame && sclk_fall && is_read
      && (st.count == `PSRP_LOAD_EDGE); // [R9]

   // only a full frame to a writable address loads
   assign write_setup = strobe_fall && (st.count == `PSRP_FRAME_BITS)
      && (st.addr == `PSRP_ADDR_SETUP); // [R8] [R2] [R3]
   assign write_ctrl = strobe_fall && (st.count == `PSRP_FRAME_BITS)
      && (st.addr == `PSRP_ADDR_CTRL); // [R8] [R2] [R3]

   // counter view or echo of the setup register
   assign view1 = st.reg1[`PSRP_VIEW_BIT] ? st.reg1
      : {COUNTER_RESULT, LOCK_STATUS, `PSRP_UNUSED4}; // [R6] [R7]

   // control echo without direction bits, then pin levels
   assign view2 = {st.reg2[`PSRP_CNT_MSB:`PSRP_TEST_BIT],
      st.reg2[`PSRP_OUT_MSB:`PSRP_OUT_LSB], io_s};

   assign read_view = (st.addr == `PSRP_ADDR_VIEW1) ? view1 : view2;

   always_comb
   begin
      next_st = st;
      next_st.sclk_d = sclk_s;
      next_st.strobe_d = strobe_s;
      if (!XTAL_RUNNING)
      begin
         // delayed copies hold while stopped, so a net level change shows as one edge on restart
         next_st.sclk_d = st.sclk_d;
         next_st.strobe_d = st.strobe_d;
      end
      if (strobe_rise)
      begin
         next_st.count = `PSRP_COUNT_ZERO;
         next_st.oe = 1'b0;
      end
      else if (in_frame && sclk_rise)
      begin
         // address first, each field msb first
         next_st.rx = {st.rx[30:0], data_s}; // [R2] [R16]
         if (st.count != `PSRP_COUNT_MAX)
         begin
            next_st.count = st.count + `PSRP_COUNT_STEP;
         end
         if (st.count == `PSRP_ADDR_BITS)
         begin
            next_st.addr = {st.rx[6:0], data_s}; // [R2]
         end
      end
      else if (load_read)
      begin
         // parallel capture, then the device owns the data line
         next_st.tx = read_view; // [R9]
         next_st.oe = 1'b1; // [R16]
      end
      else if (in_frame && sclk_fall && st.oe)
      begin
         next_st.tx = {st.tx[22:0], 1'b0}; // [R9] [R16]
      end
      if (strobe_fall)
      begin
         next_st.oe = 1'b0;
         next_st.count = `PSRP_COUNT_ZERO;
      end
      // settings change nowhere else
      if (write_setup)
      begin
         next_st.reg1 = st.rx[23:0]; // [R1] [R4] [R8]
      end
      if (write_ctrl)
      begin
         next_st.reg2 = st.rx[23:0]; // [R1] [R5] [R8]
      end
   end

   // power-on clears both registers, so the crystal bit starts at zero
   always_ff @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         st.strobe_d <= 1'b0;
         st.sclk_d <= 1'b0;
         st.count <= `PSRP_COUNT_ZERO;
         st.rx <= `PSRP_RX_RESET;
         st.addr <= `PSRP_ADDR_RESET;
         st.tx <= `PSRP_REG_RESET;
         st.oe <= 1'b0;
         st.reg1 <= `PSRP_REG_RESET; // [R15]
         st.reg2 <= `PSRP_REG_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign DATA_OUT = st.tx[23];
   assign DATA_OE = st.oe;

   assign LOOP_DIVIDER = st.reg1[`PSRP_DIV_MSB:`PSRP_DIV_LSB]; // [R4]
   assign REFERENCE_SELECT = st.reg1[`PSRP_REF_MSB:`PSRP_REF_LSB]; // [R4]
   assign OPERATION_MODE = st.reg1[`PSRP_MODE_MSB:`PSRP_MODE_LSB]; // [R4]
   assign CRYSTAL_FREQ_SELECT = st.reg1[`PSRP_XTAL_BIT]; // [R4] [R15]
   assign READBACK_VIEW_SELECT = st.reg1[`PSRP_VIEW_BIT]; // [R4]
   assign COUNTER_CONTROL = st.reg2[`PSRP_CNT_MSB:`PSRP_CNT_LSB]; // [R5]
   assign TEST_MODE = st.reg2[`PSRP_TEST_BIT]; // [R5]
   assign IO_DIRECTION = st.reg2[`PSRP_DIR_MSB:`PSRP_DIR_LSB]; // [R5]
   assign OUTPUT_DATA = st.reg2[`PSRP_OUT_MSB:`PSRP_OUT_LSB]; // [R5]

   assign gpo_select = st.reg2[`PSRP_GPO_SEL_BIT];

   // same comparator result on both pins while gpo_select is low
   psrp_phase_drv u_phase_a // [R13]
   (
      .clk(CLK),
      .reset(RESET),
      .pump_up(PUMP_UP),
      .pump_down(PUMP_DOWN),
      .as_gpo(1'b0),
      .gpo_value(1'b0),
      .pin_out(PHASE_ERROR_OUT_A),
      .pin_oe(PHASE_ERROR_OE_A)
   );

   // second pin may serve as general_output_four instead
   psrp_phase_drv u_phase_b // [R13] [R14]
   (
      .clk(CLK),
      .reset(RESET),
      .pump_up(PUMP_UP),
      .pump_down(PUMP_DOWN),
      .as_gpo(gpo_select),
      .gpo_value(st.reg2[`PSRP_GPO_VAL_BIT]),
      .pin_out(PHASE_ERROR_OUT_B),
      .pin_oe(PHASE_ERROR_OE_B)
   );

   a_setup_write: assert property ( // [R8]
      @(posedge CLK) disable iff (RESET)
      write_setup |=> (st.reg1 == $past(st.rx[23:0])))
      else $error("setup register not loaded at strobe fall");

   a_regs_hold: assert property ( // [R8]
      @(posedge CLK) disable iff (RESET)
      !strobe_fall |=> ($stable(st.reg1) && $stable(st.reg2)))
      else $error("input register changed outside strobe fall");

   a_ctrl_write: assert property ( // [R5]
      @(posedge CLK) disable iff (RESET)
      write_ctrl |=> (COUNTER_CONTROL == $past(st.rx[23:15]))
         && (OUTPUT_DATA == $past(st.rx[8:0])))
      else $error("control register fields not loaded");

   a_unmapped_addr: assert property ( // [R3]
      @(posedge CLK) disable iff (RESET)
      (strobe_fall && (st.addr != `PSRP_ADDR_SETUP) && (st.addr != `PSRP_ADDR_CTRL))
         |=> ($stable(st.reg1) && $stable(st.reg2)))
      else $error("write to undecoded address took effect");

   a_read_capture: assert property ( // [R9]
      @(posedge CLK) disable iff (RESET)
      load_read |=> (DATA_OE && (st.tx == $past(read_view))))
      else $error("read data not captured at ninth falling clock");

   a_counter_view: assert property ( // [R7]
      @(posedge CLK) disable iff (RESET)
      (load_read && (st.addr == `PSRP_ADDR_VIEW1) && !READBACK_VIEW_SELECT)
         |=> (st.tx[3:0] == `PSRP_UNUSED4) && (st.tx[5:4] == $past(LOCK_STATUS)))
      else $error("counter view layout wrong");

   a_echo_view: assert property ( // [R6]
      @(posedge CLK) disable iff (RESET)
      (load_read && (st.addr == `PSRP_ADDR_VIEW1) && READBACK_VIEW_SELECT)
         |=> (st.tx == $past(st.reg1)))
      else $error("setup echo view wrong");

   a_oe_release: assert property ( // [R16]
      @(posedge CLK) disable iff (RESET)
      strobe_fall |=> !DATA_OE ##1 !DATA_OE)
      else $error("data line still driven after frame end");

   a_xtal_stopped: assert property ( // [R11]
      @(posedge CLK) disable iff (RESET)
      !XTAL_RUNNING |=> ($stable(st.reg1) && $stable(st.reg2) && $stable(st.count)))
      else $error("serial input accepted with oscillator stopped");

   a_short_frame: assert property ( // [R2]
      @(posedge CLK) disable iff (RESET)
      (strobe_fall && (st.count != `PSRP_FRAME_BITS))
         |=> ($stable(st.reg1) && $stable(st.reg2)))
      else $error("short frame loaded a register");

   a_io_view: assert property ( // [R5]
      @(posedge CLK) disable iff (RESET)
      (load_read && (st.addr == `PSRP_ADDR_VIEW2))
         |=> (st.tx[4:0] == $past(io_s)) && (st.tx[13:5] == $past(OUTPUT_DATA)))
      else $error("control echo view wrong");

   a_shift_out: assert property ( // [R9]
      @(posedge CLK) disable iff (RESET)
      (in_frame && sclk_fall && DATA_OE && !load_read && !strobe_rise)
         |=> (DATA_OUT == $past(st.tx[22])))
      else $error("read data not shifted at falling clock");

   a_phase_parallel: assert property ( // [R13]
      @(posedge CLK) disable iff (RESET)
      $past(!gpo_select) |-> (PHASE_ERROR_OUT_A == PHASE_ERROR_OUT_B)
         && (PHASE_ERROR_OE_A == PHASE_ERROR_OE_B))
      else $error("phase outputs differ");

   a_gpo_mode: assert property ( // [R14]
      @(posedge CLK) disable iff (RESET)
      gpo_select |=> PHASE_ERROR_OE_B
         && (PHASE_ERROR_OUT_B == $past(st.reg2[`PSRP_GPO_VAL_BIT])))
      else $error("second phase pin not acting as output port");

endmodule : psrp_top

// >>> psrp_ctl_model.sv
module psrp_ctl_model
(
   output logic sclk,
   output logic strobe,
   output logic sdo,
   input wire logic line
);
   timeunit 1ns;
   timeprecision 100ps;

   // clock and strobe idle low, as the synchronisers clear to 0
   initial
   begin
      sclk = 1'b0;
      strobe = 1'b0;
      sdo = 1'b0;
   end

   // address then data, msb first; clock stands still outside frames
   task automatic frame(input logic [7:0] a, input logic [23:0] d, input int n,
      output logic [23:0] rd);
      logic [31:0] sh;
      logic rdop;
      sh = {a, d};
      rd = 24'h00_0000;
      rdop = (a == 8'hd1) || (a == 8'hd3);
      strobe = 1'b1;
      #24;
      for (int i = 0; i < n; i++)
      begin
         // released after the address: inverse of last level, never a held value
         sdo = (rdop && i >= 8) ? ~sdo : sh[31 - i];
         #24 sclk = 1'b1;
         // sample late in the high phase, past the synchroniser lag
         #23;
         if (rdop && i >= 9)
            rd = {rd[22:0], line};
         #1 sclk = 1'b0;
      end
      #47;
      if (rdop)
         rd = {rd[22:0], line};
      strobe = 1'b0;
      #60;
   endtask : frame
endmodule : psrp_ctl_model

// >>> testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic CLK, RESET, XTAL_RUNNING, SCLK_IN, STROBE_IN, sdo, line, DATA_OUT, DATA_OE;
   logic [17:0] COUNTER_RESULT;
   logic [1:0] LOCK_STATUS;
   logic [4:0] IO_PIN_IN;
   logic PUMP_UP, PUMP_DOWN, OUT_A, OE_A, OUT_B, OE_B;
   logic [15:0] LOOP_DIVIDER;
   logic [3:0] REFERENCE_SELECT;
   logic [1:0] OPERATION_MODE;
   logic CRYSTAL_FREQ_SELECT, READBACK_VIEW_SELECT, TEST_MODE;
   logic [8:0] COUNTER_CONTROL, OUTPUT_DATA;
   logic [4:0] IO_DIRECTION;
   logic [23:0] rnd;
   logic [1:0] pe;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   int m_setup = 0;
   int m_ctrl = 0;

   wire [23:0] setup_seen = {LOOP_DIVIDER, REFERENCE_SELECT, OPERATION_MODE,
      CRYSTAL_FREQ_SELECT, READBACK_VIEW_SELECT};
   wire [23:0] ctrl_seen = {COUNTER_CONTROL, TEST_MODE, IO_DIRECTION, OUTPUT_DATA};

   // pin level: device wins while it drives, else the controller
   assign line = (DATA_OE === 1'b1) ? DATA_OUT : sdo;

   psrp_ctl_model ctl
   (
      .sclk(SCLK_IN),
      .strobe(STROBE_IN),
      .sdo(sdo),
      .line(line)
   );

   psrp_top DUT
   (
      .CLK(CLK), .RESET(RESET), .XTAL_RUNNING(XTAL_RUNNING), .SCLK_IN(SCLK_IN),
      .STROBE_IN(STROBE_IN), .DATA_IN(line), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
      .COUNTER_RESULT(COUNTER_RESULT), .LOCK_STATUS(LOCK_STATUS), .IO_PIN_IN(IO_PIN_IN),
      .PUMP_UP(PUMP_UP), .PUMP_DOWN(PUMP_DOWN),
      .PHASE_ERROR_OUT_A(OUT_A), .PHASE_ERROR_OE_A(OE_A),
      .PHASE_ERROR_OUT_B(OUT_B), .PHASE_ERROR_OE_B(OE_B),
      .LOOP_DIVIDER(LOOP_DIVIDER), .REFERENCE_SELECT(REFERENCE_SELECT),
      .OPERATION_MODE(OPERATION_MODE), .CRYSTAL_FREQ_SELECT(CRYSTAL_FREQ_SELECT),
      .READBACK_VIEW_SELECT(READBACK_VIEW_SELECT), .COUNTER_CONTROL(COUNTER_CONTROL),
      .TEST_MODE(TEST_MODE), .IO_DIRECTION(IO_DIRECTION), .OUTPUT_DATA(OUTPUT_DATA)
   );

   initial
   begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end

   task automatic close_out();
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out

   // run needs about 8000 cycles
   always @(posedge CLK)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         close_out();
      end
   end

   task automatic chk24(input string nm, input logic [23:0] exp, input logic [23:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask : chk24

   task automatic chk2(input string nm, input logic [1:0] exp, input logic [1:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask : chk2

   // one frame, then model update and compare of both registers
   task automatic xfer(input logic [7:0] a, input logic [23:0] d, input int n);
      logic [23:0] r, e;
      ctl.frame(a, d, n, r);
      // stopped oscillator or short frame leaves the model untouched
      if (XTAL_RUNNING === 1'b1 && n == 32 && a == 8'hd0)
         m_setup = d;
      if (XTAL_RUNNING === 1'b1 && n == 32 && a == 8'hd2)
         m_ctrl = d;
      e = m_setup[0] ? m_setup[23:0] : {COUNTER_RESULT, LOCK_STATUS, 4'h0};
      if (a == 8'hd3)
         e = {m_ctrl[23:14], m_ctrl[8:0], IO_PIN_IN};
      @(negedge CLK);
      if (a == 8'hd1 || a == 8'hd3)
         chk24("read data", e, r);
      chk24("setup fields", m_setup[23:0], setup_seen);
      chk24("control fields", m_ctrl[23:0], ctrl_seen);
   endtask : xfer

   initial
   begin
      RESET = 1'b1;
      XTAL_RUNNING = 1'b1;
      PUMP_UP = 1'b0;
      PUMP_DOWN = 1'b0;
      COUNTER_RESULT = 18'h0_0000;
      LOCK_STATUS = 2'h0;
      IO_PIN_IN = 5'h00;
      void'($urandom(32'hed0b));
      repeat (20) @(posedge CLK);
      @(negedge CLK);
      RESET = 1'b0;
      repeat (5) @(negedge CLK);
      chk2("data enable", 2'h0, {1'b0, DATA_OE});
      xfer(8'h00, 24'h00_0000, 32); // dummy frame after power-up
      for (int k = 0; k < 4; k++)
      begin
         rnd = 24'($urandom);
         xfer(8'hd0, {rnd[23:1], k[0]}, 32);
         xfer(8'hd2, 24'($urandom), 32);
         COUNTER_RESULT = 18'($urandom);
         LOCK_STATUS = 2'($urandom);
         IO_PIN_IN = 5'($urandom);
         xfer(8'hd1, 24'($urandom), 32);
         xfer(8'hd3, 24'($urandom), 32);
      end
      xfer(8'hd4, 24'($urandom), 32);
      xfer(8'hcf, 24'($urandom), 32);
      xfer(8'hd0, 24'($urandom), 31);
      XTAL_RUNNING = 1'b0;
      xfer(8'hd2, 24'($urandom), 32);
      XTAL_RUNNING = 1'b1;
      for (int g = 0; g < 2; g++)
      begin
         rnd = 24'($urandom);
         xfer(8'hd2, {rnd[23:9], g[0], rnd[7:0]}, 32);
         for (int j = 0; j < 12; j++)
         begin
            PUMP_UP = 1'($urandom);
            PUMP_DOWN = 1'($urandom);
            @(negedge CLK);
            pe = PUMP_UP ? 2'h3 : (PUMP_DOWN ? 2'h2 : 2'h0);
            chk2("phase pin a", pe, {OE_A, OUT_A});
            chk2("phase pin b", m_ctrl[8] ? {1'b1, m_ctrl[3]} : pe, {OE_B, OUT_B});
         end
      end
      close_out();
   end
endmodule : testbench
